// File: hdl/mffc_classifier.sv
// Function
// RQ1 - field selection chosen per secure association
// RQ2 - standard mode: addresses, Ethertype or SecTAG
// RQ3 - dual tag transmit: addresses, tags, Ethertype
// RQ4 - standard mode hides tags behind SecTAG
// RQ5 - one-tag bypass keeps single tag clear
// RQ6 - one-tag bypass of dual: outer clear only
// RQ7 - MPLS bypass one label kept clear
// RQ8 - MPLS bypass two labels both classifiable
// RQ9 - both key lengths supported
// RQ10 - whole frame protected, check value after
// RQ11 - nothing past SecTAG used before decryption
module mffc_classifier #(
    parameter int SA_NUM = mffc_pkg::MFFC_SA_NUM
) (
    // clock and reset
    input  wire logic                               clk,
    input  wire logic                               reset_n,
    // per-association configuration
    input  wire logic [SA_NUM*2-1:0]                sa_mode,
    input  wire logic [SA_NUM-1:0]                  sa_key_len,
    input  wire logic [SA_NUM*mffc_pkg::MFFC_F_WIDTH-1:0] sa_field_enable,
    input  wire logic [$clog2(SA_NUM)-1:0]          frame_sa,
    input  wire logic                               frame_decrypt,
    // input byte stream
    input  wire logic                               in_valid,
    input  wire logic [7:0]                         in_data,
    input  wire logic                               in_last,
    output      logic                               in_ready,
    // output byte stream
    output      logic                               out_valid,
    output      logic [7:0]                         out_data,
    output      logic                               out_last,
    input  wire logic                               out_ready,
    // classification result
    output      logic                               fields_valid,
    output      logic [mffc_pkg::MFFC_F_WIDTH-1:0]  field_mask,
    output      logic [mffc_pkg::MFFC_ADDR_W-1:0]   class_da,
    output      logic [mffc_pkg::MFFC_ADDR_W-1:0]   class_sa,
    output      logic [mffc_pkg::MFFC_TAG_W-1:0]    class_tag1,
    output      logic [mffc_pkg::MFFC_TAG_W-1:0]    class_tag2,
    output      logic [mffc_pkg::MFFC_ETYPE_W-1:0]  class_etype,
    output      logic [mffc_pkg::MFFC_LABEL_W-1:0]  class_label2,
    output      mffc_pkg::mffc_format_type          frame_format,
    output      mffc_pkg::mffc_mode_type            frame_mode,
    output      logic                               frame_key_256,
    output      logic                               sectag_after_tag1,
    output      logic                               sectag_after_tag2,
    output      logic                               sectag_after_label,
    output      logic                               icv_after_last
);
    localparam int FW = mffc_pkg::MFFC_F_WIDTH;
    localparam int HB = 8 * mffc_pkg::MFFC_HDR_LEN;

    typedef enum {
        MFFC_ST_HEADER,
        MFFC_ST_BODY
    } mffc_state_type;

    mffc_state_type   state;
    logic [4:0]       byte_idx;
    logic [8*mffc_pkg::MFFC_HDR_LEN-1:0] hdr;
    logic             hdr_done;

    mffc_beat_if #(.W(8)) beat_up ();
    mffc_beat_if #(.W(8)) beat_dn ();

    // every byte, padding included, flows through untouched
    assign beat_up.valid = in_valid; // RQ10
    assign beat_up.data  = in_data;
    assign beat_up.last  = in_last;
    assign in_ready      = beat_up.ready;
    assign out_valid     = beat_dn.valid;
    assign out_data      = beat_dn.data;
    assign out_last      = beat_dn.last;
    assign beat_dn.ready = out_ready;

    mffc_skid_buffer #(.W(8)) u_buffer (
        .clk     (clk),
        .reset_n (reset_n),
        .up      (beat_up),
        .dn      (beat_dn)
    );

    wire take = in_valid && beat_up.ready;

    // header capture, byte 0 lands at the top
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state    <= MFFC_ST_HEADER;
            byte_idx <= 5'h00;
            hdr      <= '0;
            hdr_done <= 1'b0;
        end else if (take) begin
            if (state == MFFC_ST_HEADER) begin
                hdr[8*(mffc_pkg::MFFC_HDR_LEN-1-byte_idx) +: 8] <= in_data;
            end
            case (state)
                MFFC_ST_HEADER: begin
                    byte_idx <= byte_idx + 5'h01;
                    if (in_last) begin
                        state    <= MFFC_ST_HEADER;
                        byte_idx <= 5'h00;
                        hdr_done <= 1'b1;
                    end else if (byte_idx == 5'(mffc_pkg::MFFC_HDR_LEN - 1)) begin
                        state    <= MFFC_ST_BODY;
                        hdr_done <= 1'b1;
                    end else begin
                        hdr_done <= 1'b0;
                    end
                end
                MFFC_ST_BODY: begin
                    hdr_done <= 1'b0;
                    if (in_last) begin
                        state    <= MFFC_ST_HEADER;
                        byte_idx <= 5'h00;
                    end
                end
                default: state <= MFFC_ST_HEADER;
            endcase
        end else begin
            hdr_done <= 1'b0;
        end
    end

    function automatic logic [15:0] hdr16(input int ofs, input logic [HB-1:0] h);
        hdr16 = h[HB-8*ofs-1 -: 16];
    endfunction

    // header parse: tag and MPLS type detection
    wire [15:0] etype_12 = hdr16(mffc_pkg::MFFC_TAG1_OFS, hdr);
    wire [15:0] etype_16 = hdr16(mffc_pkg::MFFC_TAG2_OFS, hdr);
    wire [15:0] etype_20 = hdr16(20, hdr);
    wire        vlan_12  = (etype_12 == 16'h8100) || (etype_12 == 16'h88A8);
    wire        vlan_16  = (etype_16 == 16'h8100);
    wire        mpls_12  = (etype_12 == 16'h8847);
    wire        mpls_bos = hdr[HB-8*mffc_pkg::MFFC_LBL1_OFS-24];

    mffc_pkg::mffc_format_type fmt;
    assign fmt = mpls_12 ? (mpls_bos ? mffc_pkg::MFFC_FMT_MPLS_ONE
                                     : mffc_pkg::MFFC_FMT_MPLS_TWO)
               : vlan_12 ? (vlan_16 ? mffc_pkg::MFFC_FMT_DUAL_TAG
                                    : mffc_pkg::MFFC_FMT_SINGLE_TAG)
               : mffc_pkg::MFFC_FMT_UNTAGGED;

    // per-association selection
    wire [1:0]    sel_mode_raw = sa_mode[frame_sa*2 +: 2]; // RQ1
    wire [FW-1:0] sel_enable   = sa_field_enable[frame_sa*FW +: FW]; // RQ1
    wire          sel_key      = sa_key_len[frame_sa]; // RQ9
    mffc_pkg::mffc_mode_type sel_mode;
    assign sel_mode = mffc_pkg::mffc_mode_type'(sel_mode_raw);

    logic [FW-1:0] avail;
    always_comb begin
        avail = '0;
        avail[mffc_pkg::MFFC_F_DA] = 1'b1; // RQ2
        avail[mffc_pkg::MFFC_F_SA] = 1'b1; // RQ2
        if (!frame_decrypt) begin
            case (fmt)
                mffc_pkg::MFFC_FMT_UNTAGGED: begin
                    avail[mffc_pkg::MFFC_F_ETYPE] = 1'b1; // RQ2
                end
                mffc_pkg::MFFC_FMT_SINGLE_TAG: begin
                    avail[mffc_pkg::MFFC_F_TPID1] = 1'b1;
                    avail[mffc_pkg::MFFC_F_VID1]  = 1'b1;
                    avail[mffc_pkg::MFFC_F_ETYPE] = 1'b1;
                end
                mffc_pkg::MFFC_FMT_DUAL_TAG: begin
                    avail[mffc_pkg::MFFC_F_TPID1] = 1'b1; // RQ3
                    avail[mffc_pkg::MFFC_F_VID1]  = 1'b1; // RQ3
                    avail[mffc_pkg::MFFC_F_TPID2] = 1'b1; // RQ3
                    avail[mffc_pkg::MFFC_F_VID2]  = 1'b1; // RQ3
                    avail[mffc_pkg::MFFC_F_ETYPE] = 1'b1; // RQ3
                end
                mffc_pkg::MFFC_FMT_MPLS_ONE: begin
                    avail[mffc_pkg::MFFC_F_ETYPE]  = 1'b1; // RQ7
                    avail[mffc_pkg::MFFC_F_LABEL1] = 1'b1; // RQ7
                end
                default: begin
                    avail[mffc_pkg::MFFC_F_ETYPE]  = 1'b1; // RQ8
                    avail[mffc_pkg::MFFC_F_LABEL1] = 1'b1; // RQ8
                    avail[mffc_pkg::MFFC_F_LABEL2] = 1'b1; // RQ8
                end
            endcase
        end else begin
            // only clear bytes up to the SecTAG are usable
            avail[mffc_pkg::MFFC_F_SECTAG] = 1'b1; // RQ11
            case (sel_mode)
                mffc_pkg::MFFC_MODE_ONE_TAG_BYPASS: begin
                    avail[mffc_pkg::MFFC_F_TPID1] = 1'b1; // RQ5
                    avail[mffc_pkg::MFFC_F_VID1]  = 1'b1; // RQ5
                end
                mffc_pkg::MFFC_MODE_TWO_TAG_BYPASS: begin
                    avail[mffc_pkg::MFFC_F_TPID1] = 1'b1;
                    avail[mffc_pkg::MFFC_F_VID1]  = 1'b1;
                    avail[mffc_pkg::MFFC_F_TPID2] = 1'b1;
                    avail[mffc_pkg::MFFC_F_VID2]  = 1'b1;
                end
                mffc_pkg::MFFC_MODE_MPLS_BYPASS: begin
                    avail[mffc_pkg::MFFC_F_ETYPE]  = 1'b1; // RQ7
                    avail[mffc_pkg::MFFC_F_LABEL1] = 1'b1; // RQ7
                    avail[mffc_pkg::MFFC_F_LABEL2] = !mpls_bos; // RQ8
                end
                default: begin
                    // standard mode: tags are hidden behind the SecTAG
                end
            endcase
        end
    end

    // SecTAG placement for the transform stage
    wire std_mode   = (sel_mode == mffc_pkg::MFFC_MODE_STANDARD);
    wire one_bypass = (sel_mode == mffc_pkg::MFFC_MODE_ONE_TAG_BYPASS) && vlan_12; // RQ5 RQ6
    wire two_bypass = (sel_mode == mffc_pkg::MFFC_MODE_TWO_TAG_BYPASS) && vlan_12 && vlan_16;
    wire lbl_bypass = (sel_mode == mffc_pkg::MFFC_MODE_MPLS_BYPASS) && mpls_12; // RQ7

    // field slices, byte 0 sits at the top of hdr
    wire [mffc_pkg::MFFC_ADDR_W-1:0]  hdr_da     = hdr[HB-8*mffc_pkg::MFFC_DA_OFS-1 -: 48];
    wire [mffc_pkg::MFFC_ADDR_W-1:0]  hdr_sa     = hdr[HB-8*mffc_pkg::MFFC_SA_OFS-1 -: 48];
    wire [mffc_pkg::MFFC_TAG_W-1:0]   hdr_tag1   = hdr[HB-8*mffc_pkg::MFFC_TAG1_OFS-1 -: 32];
    wire [mffc_pkg::MFFC_TAG_W-1:0]   hdr_tag2   = hdr[HB-8*mffc_pkg::MFFC_TAG2_OFS-1 -: 32];
    wire [mffc_pkg::MFFC_LABEL_W-1:0] hdr_label2 = hdr[HB-8*mffc_pkg::MFFC_LBL2_OFS-1 -: 32];
    // inner tag only counts behind an outer one, so payload bytes never look like a tag
    wire [mffc_pkg::MFFC_ETYPE_W-1:0] hdr_etype  = vlan_12 ? (vlan_16 ? etype_20 : etype_16)
                                                           : etype_12;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fields_valid       <= 1'b0;
            field_mask         <= '0;
            class_da           <= '0;
            class_sa           <= '0;
            class_tag1         <= '0;
            class_tag2         <= '0;
            class_etype        <= '0;
            class_label2       <= '0;
            frame_format       <= mffc_pkg::MFFC_FMT_UNTAGGED;
            frame_mode         <= mffc_pkg::MFFC_MODE_STANDARD;
            frame_key_256      <= mffc_pkg::MFFC_KEY_128;
            sectag_after_tag1  <= 1'b0;
            sectag_after_tag2  <= 1'b0;
            sectag_after_label <= 1'b0;
            icv_after_last     <= 1'b0;
        end else begin
            fields_valid <= hdr_done;
            if (hdr_done) begin
                field_mask   <= avail & sel_enable; // RQ1
                class_da     <= hdr_da;
                class_sa     <= hdr_sa;
                class_tag1   <= hdr_tag1;
                class_tag2   <= hdr_tag2;
                class_etype  <= hdr_etype;
                class_label2 <= hdr_label2; // RQ8
                frame_format <= fmt;
                frame_mode   <= sel_mode;
                frame_key_256 <= sel_key; // RQ9
                // standard mode puts every tag behind the SecTAG
                sectag_after_tag1  <= !std_mode && (one_bypass || two_bypass); // RQ4 RQ6
                sectag_after_tag2  <= !std_mode && two_bypass;
                sectag_after_label <= !std_mode && lbl_bypass; // RQ7 RQ8
                icv_after_last     <= 1'b1; // RQ10
            end
        end
    end
endmodule // mffc_classifier

// File: hdl/mffc_pkg.sv
package mffc_pkg;

    // frame formats as seen on the classifier's input
    typedef enum logic [2:0] {
        MFFC_FMT_UNTAGGED,
        MFFC_FMT_SINGLE_TAG,
        MFFC_FMT_DUAL_TAG,
        MFFC_FMT_MPLS_ONE,
        MFFC_FMT_MPLS_TWO
    } mffc_format_type;

    // encapsulation modes chosen for each secure association entry
    typedef enum logic [1:0] {
        MFFC_MODE_STANDARD,
        MFFC_MODE_ONE_TAG_BYPASS,
        MFFC_MODE_TWO_TAG_BYPASS,
        MFFC_MODE_MPLS_BYPASS
    } mffc_mode_type;

    // field-valid mask bit positions
    localparam int MFFC_F_DA     = 0;
    localparam int MFFC_F_SA     = 1;
    localparam int MFFC_F_TPID1  = 2;
    localparam int MFFC_F_VID1   = 3;
    localparam int MFFC_F_TPID2  = 4;
    localparam int MFFC_F_VID2   = 5;
    localparam int MFFC_F_ETYPE  = 6;
    localparam int MFFC_F_LABEL1 = 7;
    localparam int MFFC_F_LABEL2 = 8;
    localparam int MFFC_F_SECTAG = 9;
    localparam int MFFC_F_WIDTH  = 10;

    // header widths and byte offsets
    localparam int MFFC_BYTE_W   = 8;
    localparam int MFFC_ADDR_W   = 48;
    localparam int MFFC_TAG_W    = 32;
    localparam int MFFC_VID_W    = 12;
    localparam int MFFC_LABEL_W  = 32;
    localparam int MFFC_ETYPE_W  = 16;
    localparam int MFFC_DA_OFS   = 0;
    localparam int MFFC_SA_OFS   = 6;
    localparam int MFFC_TAG1_OFS = 12;
    localparam int MFFC_TAG2_OFS = 16;
    localparam int MFFC_LBL1_OFS = 14;
    localparam int MFFC_LBL2_OFS = 18;
    localparam int MFFC_HDR_LEN  = 22;
    localparam int MFFC_SA_NUM   = 16;

    // cipher key lengths
    localparam logic MFFC_KEY_128 = 1'b0;
    localparam logic MFFC_KEY_256 = 1'b1;

    localparam logic [15:0] MFFC_RESET_VID_MASK = 16'h0000;

endpackage

// File: hdl/mffc_beat_if.sv
interface mffc_beat_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    logic         last;

    modport source (output valid, output data, output last, input ready);
    modport sink   (input valid, input data, input last, output ready);
endinterface

// File: hdl/mffc_skid_buffer.sv
module mffc_skid_buffer #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // streams
    mffc_beat_if.sink   up,
    mffc_beat_if.source dn
);
    logic [W:0] slot [2];
    logic       rd_ptr;
    logic       wr_ptr;
    logic [1:0] count;

    // two entries so a stalled receiver never drops a byte
    wire push = up.valid && up.ready;
    wire pop  = dn.valid && dn.ready;

    assign up.ready = (count != 2'h2);
    assign dn.valid = (count != 2'h0);
    assign dn.data  = slot[rd_ptr][W-1:0];
    assign dn.last  = slot[rd_ptr][W];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_ptr   <= 1'b0;
            wr_ptr   <= 1'b0;
            count    <= 2'h0;
            slot[0]  <= '0;
            slot[1]  <= '0;
        end else begin
            if (push) begin
                slot[wr_ptr] <= {up.last, up.data};
                wr_ptr       <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule // mffc_skid_buffer

// File: verif/mffc_classifier_props.sv
module mffc_classifier_props #(
    parameter int SA_NUM = 16
) (
    // clock and reset
    input wire logic                          clk,
    input wire logic                          reset_n,
    // configuration
    input wire logic [SA_NUM-1:0]             sa_key_len,
    input wire logic [SA_NUM*10-1:0]          sa_field_enable,
    input wire logic [$clog2(SA_NUM)-1:0]     frame_sa,
    input wire logic                          frame_decrypt,
    // output stream
    input wire logic                          out_valid,
    input wire logic [7:0]                    out_data,
    input wire logic                          out_ready,
    // results
    input wire logic                          fields_valid,
    input wire logic [9:0]                    field_mask,
    input wire mffc_pkg::mffc_format_type     frame_format,
    input wire mffc_pkg::mffc_mode_type       frame_mode,
    input wire logic                          frame_key_256,
    input wire logic                          sectag_after_tag1,
    input wire logic                          sectag_after_tag2,
    input wire logic                          sectag_after_label
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // enables of the association that the current frame uses
    wire logic [9:0] en = sa_field_enable[frame_sa*10 +: 10];
    wire logic       fv_tx = fields_valid && !frame_decrypt;
    wire logic       fv_rx = fields_valid && frame_decrypt;
    property p_sel; fields_valid |-> (field_mask & ~en) == 10'h000; endproperty
    property p_std_rx; fv_rx && frame_mode == 2'h0 |-> field_mask == (en & 10'h203); endproperty
    property p_dual_tx; fv_tx && frame_format == 3'h2 |-> field_mask == (en & 10'h07F); endproperty
    property p_std_hide; fields_valid && frame_mode == 2'h0
        |-> !(sectag_after_tag1 || sectag_after_tag2 || sectag_after_label); endproperty
    property p_one_tx; fv_tx && frame_mode == 2'h1 && frame_format inside {3'h1, 3'h2}
        |-> sectag_after_tag1 && !sectag_after_tag2; endproperty
    property p_one_rx; fv_rx && frame_mode == 2'h1 |-> field_mask[5:4] == 2'h0; endproperty
    property p_mpls; fv_tx && frame_mode == 2'h3 && frame_format inside {3'h3, 3'h4}
        |-> sectag_after_label; endproperty
    property p_two_lbl; fields_valid && frame_mode == 2'h3 && frame_format == 3'h4
        |-> field_mask[8:7] == en[8:7]; endproperty
    property p_key; fields_valid |-> frame_key_256 == sa_key_len[frame_sa]; endproperty
    property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_data); endproperty
    a_sel: assert property (p_sel) else $error("mask outside enables");
    a_std_rx: assert property (p_std_rx) else $error("rx standard mask");
    a_dual_tx: assert property (p_dual_tx) else $error("dual tag tx mask");
    a_std_hide: assert property (p_std_hide) else $error("standard mode tag clear");
    a_one_tx: assert property (p_one_tx) else $error("one tag bypass placement");
    a_one_rx: assert property (p_one_rx) else $error("inner tag classified");
    a_mpls: assert property (p_mpls) else $error("label not clear");
    a_two_lbl: assert property (p_two_lbl) else $error("second label missing");
    a_key: assert property (p_key) else $error("key length");
    a_hold: assert property (p_hold) else $error("stalled byte changed");
    c_rx: cover property (fv_rx);
    c_two: cover property (fields_valid && frame_format == 3'h4);
    c_stall: cover property (out_valid && !out_ready);
endmodule // mffc_classifier_props

bind mffc_classifier mffc_classifier_props #(.SA_NUM(SA_NUM)) mffc_classifier_props_i (
    .clk(clk), .reset_n(reset_n), .sa_key_len(sa_key_len), .sa_field_enable(sa_field_enable),
    .frame_sa(frame_sa), .frame_decrypt(frame_decrypt), .out_valid(out_valid),
    .out_data(out_data), .out_ready(out_ready), .fields_valid(fields_valid),
    .field_mask(field_mask), .frame_format(frame_format), .frame_mode(frame_mode),
    .frame_key_256(frame_key_256), .sectag_after_tag1(sectag_after_tag1),
    .sectag_after_tag2(sectag_after_tag2), .sectag_after_label(sectag_after_label));

// File: verif/mffc_line_sink.sv
module mffc_line_sink (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // stall control
    input  wire logic       slow,
    // byte stream from the block
    input  wire logic       out_valid,
    input  wire logic [7:0] out_data,
    input  wire logic       out_last,
    output      logic       out_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] phase;
    logic [8:0] got_q[$];
    // slow takes one byte in four, enough to fill the two-entry buffer
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phase     <= 2'h0;
            out_ready <= 1'b0;
        end else begin
            phase     <= phase + 2'h1;
            out_ready <= !slow || (phase == 2'h3);
            if (out_valid && out_ready) got_q.push_back({out_last, out_data});
        end
    end
endmodule // mffc_line_sink

// File: verif/mffc_classifier_tb_top.sv
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end

module mffc_classifier_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int N = 26;
    logic                      clk, reset_n, slow, frame_decrypt, in_valid, in_last, in_ready;
    logic                      out_valid, out_last, out_ready, fields_valid, frame_key_256;
    logic                      sectag_after_tag1, sectag_after_tag2, sectag_after_label;
    logic                      icv_after_last;
    logic [7:0]                in_data, out_data, frm[N];
    logic [31:0]               sa_mode;
    logic [15:0]               sa_key_len, class_etype;
    logic [159:0]              sa_field_enable;
    logic [3:0]                frame_sa;
    logic [9:0]                field_mask, exp_mask;
    logic [2:0]                exp_after;
    logic [47:0]               class_da, class_sa;
    logic [31:0]               class_tag1, class_tag2, class_label2;
    mffc_pkg::mffc_format_type frame_format, exp_fmt;
    mffc_pkg::mffc_mode_type   frame_mode;
    int                        failures, checked, seen, stalls, eo;

    mffc_classifier mffc_classifier_i (.clk(clk), .reset_n(reset_n), .sa_mode(sa_mode),
        .sa_key_len(sa_key_len), .sa_field_enable(sa_field_enable), .frame_sa(frame_sa),
        .frame_decrypt(frame_decrypt), .in_valid(in_valid), .in_data(in_data),
        .in_last(in_last), .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data),
        .out_last(out_last), .out_ready(out_ready), .fields_valid(fields_valid),
        .field_mask(field_mask), .class_da(class_da), .class_sa(class_sa),
        .class_tag1(class_tag1), .class_tag2(class_tag2), .class_etype(class_etype),
        .class_label2(class_label2), .frame_format(frame_format), .frame_mode(frame_mode),
        .frame_key_256(frame_key_256), .sectag_after_tag1(sectag_after_tag1),
        .sectag_after_tag2(sectag_after_tag2), .sectag_after_label(sectag_after_label),
        .icv_after_last(icv_after_last));
    mffc_line_sink mffc_line_sink_i (.clk(clk), .reset_n(reset_n), .slow(slow),
        .out_valid(out_valid), .out_data(out_data), .out_last(out_last), .out_ready(out_ready));

    task automatic report_and_stop;
        if (failures == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // results are judged in the cycle the pulse stands
    always @(posedge clk) begin
        if (fields_valid === 1'b1) begin
            seen++;
            `CHK(field_mask, exp_mask)
            `CHK({sectag_after_tag1, sectag_after_tag2, sectag_after_label}, exp_after)
            `CHK(frame_key_256, sa_key_len[frame_sa])
            `CHK(class_da, 48'h0A0B0C0D0E0F)
            `CHK(class_sa, 48'h464748494A4B)
            `CHK(frame_mode, sa_mode[frame_sa*2 +: 2])
            `CHK(class_etype, {frm[eo], frm[eo + 1]})
            `CHK(icv_after_last, 1'b1)
            if (exp_fmt == 3'h2) `CHK(class_tag2, {frm[16], frm[17], frm[18], frm[19]})
            if (!frame_decrypt) `CHK(frame_format, exp_fmt)
            if (exp_fmt inside {3'h1, 3'h2})
                `CHK(class_tag1, {frm[12], frm[13], frm[14], frm[15]})
            if (exp_fmt == 3'h4) `CHK(class_label2, {frm[18], frm[19], frm[20], frm[21]})
        end
    end

    task automatic run_case(input logic [2:0] kind, input logic [1:0] mode,
                            input logic dec, input logic [3:0] sa, input logic [9:0] tbl);
        int i, n, s0;
        logic rdy;
        logic [8:0] b;
        logic [15:0] ety;
        ety = dec ? 16'h88E5 : 16'h0800;
        for (i = 0; i < N; i++) frm[i] = (i < 6) ? 8'h0A + i[7:0] : 8'h40 + i[7:0];
        case (kind)
            3'h0: {frm[12], frm[13]} = ety;
            3'h1: {frm[12], frm[13], frm[14], frm[15], frm[16], frm[17]} = {32'h81000005, ety};
            3'h2: {frm[12], frm[13], frm[14], frm[15], frm[16], frm[17], frm[18], frm[19],
                   frm[20], frm[21]} = {32'h88A80007, 32'h81000009, ety};
            3'h3: {frm[12], frm[13], frm[14], frm[15], frm[16], frm[17]} = 48'h884700012140;
            default: {frm[12], frm[13], frm[14], frm[15], frm[16], frm[17], frm[18], frm[19],
                      frm[20], frm[21]} = 80'h8847000120400002_3140;
        endcase
        exp_fmt = mffc_pkg::mffc_format_type'(kind);
        eo = (kind == 3'h1) ? 16 : ((kind == 3'h2) ? 20 : 12);
        exp_mask = tbl & sa_field_enable[sa*10 +: 10];
        // two-tag bypass keeps both tags ahead of the SecTAG
        exp_after = (mode == 2'h1) ? 3'h4 : (mode == 2'h2) ? 3'h6 : (mode == 2'h3) ? 3'h1 : 3'h0;
        s0 = seen;
        @(posedge clk);
        sa_mode[sa*2 +: 2] <= mode;
        frame_sa <= sa;
        frame_decrypt <= dec;
        for (i = 0; i < N; i++) begin
            in_valid <= 1'b1;
            in_data <= frm[i];
            in_last <= (i == N - 1);
            n = 0;
            do begin
                @(negedge clk);
                rdy = in_ready;
                if (rdy !== 1'b1) stalls++;
                @(posedge clk);
                n++;
            end while (rdy !== 1'b1 && n < 200);
            if (n >= 200) begin failures++; report_and_stop(); end
        end
        in_valid <= 1'b0;
        in_last <= 1'b0;
        for (n = 0; n < 400 && mffc_line_sink_i.got_q.size() < N; n++) @(posedge clk);
        if (mffc_line_sink_i.got_q.size() < N) begin failures++; report_and_stop(); end
        `CHK(seen, s0 + 1)
        for (i = 0; i < N; i++) begin
            b = mffc_line_sink_i.got_q.pop_front();
            `CHK(b, {i == N - 1, frm[i]})
        end
    endtask

    task automatic scen_reset;
        `CHK(in_ready, 1'b1)
        `CHK({out_valid, fields_valid}, 2'h0)
    endtask
    task automatic scen_standard;
        run_case(3'h0, 2'h0, 1'h0, 4'h0, 10'h043);
        run_case(3'h1, 2'h0, 1'h0, 4'h0, 10'h04F);
        run_case(3'h2, 2'h0, 1'h0, 4'h0, 10'h07F);
        run_case(3'h0, 2'h0, 1'h1, 4'h0, 10'h203);
    endtask
    task automatic scen_tag_bypass;
        run_case(3'h1, 2'h1, 1'h0, 4'h0, 10'h04F);
        run_case(3'h1, 2'h1, 1'h1, 4'h0, 10'h20F);
        run_case(3'h2, 2'h1, 1'h0, 4'h0, 10'h07F);
        run_case(3'h2, 2'h2, 1'h1, 4'h0, 10'h23F);
    endtask
    task automatic scen_mpls;
        run_case(3'h3, 2'h3, 1'h0, 4'h0, 10'h0C3);
        run_case(3'h3, 2'h3, 1'h1, 4'h0, 10'h2C3);
        run_case(3'h4, 2'h3, 1'h0, 4'h0, 10'h1C3);
        run_case(3'h4, 2'h3, 1'h1, 4'h1, 10'h3C3);
    endtask
    task automatic scen_stall;
        int s;
        s = stalls;
        @(posedge clk);
        slow <= 1'b1;
        run_case(3'h2, 2'h2, 1'h0, 4'h1, 10'h07F);
        `CHK(stalls > s, 1'b1)
        slow <= 1'b0;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        {reset_n, slow, in_valid, in_data, in_last, frame_decrypt, frame_sa} = '0;
        sa_mode = '0;
        sa_key_len = 16'h0002;
        sa_field_enable = {{14{10'h3FF}}, 10'h155, 10'h3FF};
        {failures, checked, seen, stalls} = '0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        scen_reset();
        scen_standard();
        scen_tag_bypass();
        scen_mpls();
        scen_stall();
        report_and_stop();
    end
endmodule // mffc_classifier_tb_top
